// *** hdl/cecp_map.vh ***
`ifndef CECP_MAP_VH
`define CECP_MAP_VH
// register byte offsets
`define CECP_OFF_CTRL 8'h00
`define CECP_OFF_SRC_ENA 8'h04
`define CECP_OFF_PRIO 8'h08
`define CECP_OFF_STATUS 8'h0C
`define CECP_OFF_IRQ_STAT 8'h10
`define CECP_OFF_IRQ_MASK 8'h14
`define CECP_OFF_VEC_BASE 8'h18
`define CECP_OFF_TRAP_BASE 8'h1C
`define CECP_OFF_CSA_FREE 8'h20
`define CECP_OFF_CAUSE 8'h24
`define CECP_OFF_PSW 8'h28
`define CECP_OFF_PREVIOUS_CONTEXT_INFO 8'h2C
`define CECP_OFF_CSA_ADDR 8'h30
`define CECP_OFF_RESUME 8'h34
// ctrl fields
`define CECP_CTRL_IE 0
// program status word fields
`define CECP_PSW_IO_LO 10
`define CECP_PSW_IO_HI 11
// io modes
`define CECP_IO_USER0 2'h0
`define CECP_IO_USER1 2'h1
`define CECP_IO_SUPER 2'h2
// status event bits
`define CECP_EV_IRQ 0
`define CECP_EV_TRAP 1
`define CECP_EV_CALL 2
`define CECP_EV_DENY 3
`define CECP_EV_CSA 4
// context save area layout
`define CECP_CSA_WORDS 16
`define CECP_CSA_ALIGN_BITS 6
// handler block size shift (32 bytes per entry block)
`define CECP_VEC_SHIFT 5
// reset values
`define CECP_RST_PSW 32'h00000800
`define CECP_RST_VEC 32'h00000000
`define CECP_RST_CSA 32'h00010000
`endif

// *** hdl/cecp_core.v ***
// Design decisions made here: the AXI4-Lite slave port and the placing of the registers.
`include "cecp_map.vh"
module cecp_core #(
   // up to 255 sources and priority levels
   parameter NSRC = 255,
   parameter PW = 8
) (
   input wire sys_clk_in,
   input wire reset_n_in,
   // axi4-lite slave
   input wire [7:0] s_axi_awaddr_in,
   input wire s_axi_awvalid_in,
   output reg s_axi_awready_out,
   input wire [31:0] s_axi_wdata_in,
   input wire [3:0] s_axi_wstrb_in,
   input wire s_axi_wvalid_in,
   output reg s_axi_wready_out,
   output reg [1:0] s_axi_bresp_out,
   output reg s_axi_bvalid_out,
   input wire s_axi_bready_in,
   input wire [7:0] s_axi_araddr_in,
   input wire s_axi_arvalid_in,
   output reg s_axi_arready_out,
   output reg [31:0] s_axi_rdata_out,
   output reg [1:0] s_axi_rresp_out,
   output reg s_axi_rvalid_out,
   input wire s_axi_rready_in,
   // service request lines, one per source
   input wire [NSRC-1:0] srv_req_in,
   // request_priority_number per source, packed
   input wire [NSRC*PW-1:0] request_priority_number_in,
   // trap request from pipeline
   input wire trap_req_in,
   input wire [2:0] trap_class_in,
   input wire [7:0] trap_cause_number_in,
   // function call from pipeline
   input wire call_req_in,
   input wire [31:0] call_target_in,
   // current pc, for context save
   input wire [31:0] pc_in,
   // pipeline access attempts checked against io mode
   input wire periph_acc_in,
   input wire periph_prot_in,
   input wire sysreg_acc_in,
   input wire int_toggle_in,
   // return from handler
   input wire ret_in,
   // fetch redirect
   output reg redirect_out,
   output reg [31:0] redirect_pc_out,
   // implicit data register write (trap cause)
   output reg d15_we_out,
   output reg [31:0] d15_data_out,
   // context store to memory
   output reg ctx_store_out,
   output reg ctx_upper_out,
   output reg [31:0] ctx_addr_out,
   // privilege denial pulse
   output reg access_deny_out,
   // interrupt line
   output reg irq_out,
   // acknowledge of taken request
   output reg [PW-1:0] ack_prio_out
);
   // save sequencer states
   localparam ST_IDLE = 2'h0; // idle
   localparam ST_SAVEU = 2'h1; // store upper context
   localparam ST_SAVEL = 2'h2; // store lower context
   // only the second stage reads the first
   reg rst_s1_q; // reset sync stage 1
   reg rst_n_q; // synchronised reset
   // reset release through two flops
   always @(posedge sys_clk_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_s1_q <= 1'b0;
         rst_n_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n_q <= rst_s1_q;
      end
   end
   // architectural and control registers
   reg [31:0] ctrl_q; // interrupt enable bit
   reg [31:0] psw_q; // program_status_word
   reg [31:0] previous_context_info_q; // previous_context_info link
   reg [31:0] vec_base_q; // interrupt vector base
   reg [31:0] trap_base_q; // trap vector base
   reg [31:0] csa_free_q; // free list head
   reg [31:0] cause_q; // last trap class and cause
   reg [4:0] stat_q; // sticky events
   reg [4:0] mask_q; // event mask
   reg [PW-1:0] cur_prio_q; // priority being serviced
   reg [PW-1:0] prio_stack_q [0:15]; // saved priorities for nesting
   reg [3:0] depth_q; // nesting depth
   reg [1:0] st_q; // save state
   // return point and handler entry for the switch
   reg [31:0] resume_q; // return pc
   reg [31:0] pend_target_q; // target after saving
   // io mode field of the status word
   wire [1:0] io_mode = psw_q[`CECP_PSW_IO_HI:`CECP_PSW_IO_LO];
   reg [PW-1:0] win_prio;
   reg win_valid;
   integer i;
   // highest pending number wins
   always @* begin
      win_prio = {PW{1'b0}};
      win_valid = 1'b0;
      for (i = 0; i < NSRC; i = i + 1) begin
         // distinct numbers assumed, so first-highest is unique
         if (srv_req_in[i] && request_priority_number_in[i*PW +: PW] > win_prio) begin
            win_prio = request_priority_number_in[i*PW +: PW];
            win_valid = 1'b1;
         end
      end
   end
   // a full nesting stack leaves the request pending, so it never wraps
   // strictly greater accepted only
   wire take_irq = win_valid && ctrl_q[`CECP_CTRL_IE] && (win_prio > cur_prio_q)
      && st_q == ST_IDLE && !trap_req_in && depth_q != 4'hF;
   function deny_f;
      input [1:0] mode;
      input per;
      input prot;
      input sysr;
      input tog;
      begin
         case (mode)
            `CECP_IO_USER0: deny_f = per | sysr | tog;
            `CECP_IO_USER1: deny_f = (per & prot) | sysr;
            default: deny_f = 1'b0;
         endcase
      end
   endfunction
   // one flag for any refused access
   wire deny = deny_f(io_mode, periph_acc_in, periph_prot_in, sysreg_acc_in, int_toggle_in);
   // switch sources, trap first
   // any break starts a context switch unless the list head is misaligned
   wire do_trap = trap_req_in && st_q == ST_IDLE;
   // calls yield to traps and interrupts
   wire do_call = call_req_in && st_q == ST_IDLE && !trap_req_in && !take_irq;
   wire start = do_trap | take_irq | do_call;
   wire csa_ok = csa_free_q[`CECP_CSA_ALIGN_BITS-1:0] == 6'h00;
   // axi write path
   reg [7:0] aw_q;
   reg aw_got_q;
   reg [31:0] w_q;
   reg [3:0] ws_q;
   reg w_got_q;
   // write lands once address and data are both held
   wire wr_go = aw_got_q && w_got_q && !s_axi_bvalid_out;
   // byte-lane merge for strobed writes
   function [31:0] merge_f;
      input [31:0] old;
      input [31:0] nw;
      input [3:0] st;
      integer k;
      begin
         merge_f = old;
         for (k = 0; k < 4; k = k + 1)
            if (st[k]) merge_f[k*8 +: 8] = nw[k*8 +: 8];
      end
   endfunction
   wire [31:0] wm = w_q;
   // events feeding the sticky status bits
   wire [4:0] ev_now = {~csa_ok & start, deny, do_call, do_trap, take_irq};
   // axi handshake process
   always @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         // bus idle while in reset
         s_axi_awready_out <= 1'b0;
         s_axi_wready_out <= 1'b0;
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= 2'h0;
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rresp_out <= 2'h0;
         s_axi_rdata_out <= 32'h00000000;
         aw_q <= 8'h00;
         aw_got_q <= 1'b0;
         w_q <= 32'h00000000;
         ws_q <= 4'h0;
         w_got_q <= 1'b0;
      end else begin
         // readies pulse every other cycle while free
         s_axi_awready_out <= !aw_got_q && !s_axi_awready_out;
         s_axi_wready_out <= !w_got_q && !s_axi_wready_out;
         // address taken
         if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_q <= s_axi_awaddr_in;
            aw_got_q <= 1'b1;
            s_axi_awready_out <= 1'b0;
         end
         // data taken
         if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_q <= s_axi_wdata_in;
            ws_q <= s_axi_wstrb_in;
            w_got_q <= 1'b1;
            s_axi_wready_out <= 1'b0;
         end
         // response once both held
         if (wr_go) begin
            s_axi_bvalid_out <= 1'b1;
            s_axi_bresp_out <= (aw_q > `CECP_OFF_RESUME || aw_q[1:0] != 2'h0) ? 2'h2 : 2'h0;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end else if (s_axi_bvalid_out && s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
         end
         // read channel
         s_axi_arready_out <= !s_axi_rvalid_out && !s_axi_arready_out;
         if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b1;
            s_axi_rresp_out <= 2'h0;
            // read data registered with the handshake
            case (s_axi_araddr_in)
               `CECP_OFF_CTRL: s_axi_rdata_out <= ctrl_q;
               `CECP_OFF_PRIO: s_axi_rdata_out <= {{(32-PW){1'b0}}, cur_prio_q};
               `CECP_OFF_STATUS: s_axi_rdata_out <= {24'h000000, io_mode, st_q, depth_q};
               `CECP_OFF_IRQ_STAT: s_axi_rdata_out <= {27'h0000000, stat_q};
               `CECP_OFF_IRQ_MASK: s_axi_rdata_out <= {27'h0000000, mask_q};
               `CECP_OFF_VEC_BASE: s_axi_rdata_out <= vec_base_q;
               `CECP_OFF_TRAP_BASE: s_axi_rdata_out <= trap_base_q;
               `CECP_OFF_CSA_FREE: s_axi_rdata_out <= csa_free_q;
               `CECP_OFF_CAUSE: s_axi_rdata_out <= cause_q;
               `CECP_OFF_PSW: s_axi_rdata_out <= psw_q;
               `CECP_OFF_PREVIOUS_CONTEXT_INFO: s_axi_rdata_out <= previous_context_info_q;
               `CECP_OFF_RESUME: s_axi_rdata_out <= resume_q;
               default: begin
                  // unmapped: decode error
                  s_axi_rdata_out <= 32'h00000000;
                  s_axi_rresp_out <= 2'h3;
               end
            endcase
         end else if (s_axi_rvalid_out && s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
         end
      end
   end
   // core state process
   always @(posedge sys_clk_in or negedge rst_n_q) begin
      if (!rst_n_q) begin
         // all outputs low while in reset
         ctrl_q <= 32'h00000000;
         psw_q <= `CECP_RST_PSW;
         previous_context_info_q <= 32'h00000000;
         vec_base_q <= `CECP_RST_VEC;
         trap_base_q <= `CECP_RST_VEC;
         csa_free_q <= `CECP_RST_CSA;
         cause_q <= 32'h00000000;
         stat_q <= 5'h00;
         mask_q <= 5'h00;
         cur_prio_q <= {PW{1'b0}};
         depth_q <= 4'h0;
         st_q <= ST_IDLE;
         resume_q <= 32'h00000000;
         pend_target_q <= 32'h00000000;
         redirect_out <= 1'b0;
         redirect_pc_out <= 32'h00000000;
         d15_we_out <= 1'b0;
         d15_data_out <= 32'h00000000;
         ctx_store_out <= 1'b0;
         ctx_upper_out <= 1'b0;
         ctx_addr_out <= 32'h00000000;
         access_deny_out <= 1'b0;
         irq_out <= 1'b0;
         ack_prio_out <= {PW{1'b0}};
      end else begin
         // one-cycle strobes default low
         redirect_out <= 1'b0;
         d15_we_out <= 1'b0;
         ctx_store_out <= 1'b0;
         access_deny_out <= deny;
         // register writes
         if (wr_go) begin
            // read-only and unused offsets are ignored
            case (aw_q)
               `CECP_OFF_CTRL: ctrl_q <= merge_f(ctrl_q, wm, ws_q);
               `CECP_OFF_IRQ_MASK: mask_q <= wm[4:0];
               `CECP_OFF_VEC_BASE: vec_base_q <= merge_f(vec_base_q, wm, ws_q);
               `CECP_OFF_TRAP_BASE: trap_base_q <= merge_f(trap_base_q, wm, ws_q);
               `CECP_OFF_CSA_FREE: csa_free_q <= merge_f(csa_free_q, wm, ws_q);
               `CECP_OFF_PSW: psw_q <= merge_f(psw_q, wm, ws_q);
               default: ;
            endcase
         end
         // sticky events, set wins over write-one clear
         stat_q <= (stat_q & ~((wr_go && aw_q == `CECP_OFF_IRQ_STAT) ? wm[4:0] : 5'h00))
            | ev_now;
         // level interrupt from unmasked sticky bits
         irq_out <= |(stat_q & mask_q);
         // context switch start
         // a misaligned list head holds the switch off
         if (start && csa_ok) begin
            resume_q <= pc_in;
            st_q <= ST_SAVEU;
            if (do_trap) begin
               // class in 3 bits, eight classes
               cause_q <= {21'h000000, trap_class_in, trap_cause_number_in};
               pend_target_q <= trap_base_q + {24'h000000, trap_class_in, `CECP_VEC_SHIFT'h00};
               d15_we_out <= 1'b1;
               d15_data_out <= {24'h000000, trap_cause_number_in};
            end else if (take_irq) begin
               pend_target_q <= vec_base_q + ({{(32-PW){1'b0}}, win_prio} << `CECP_VEC_SHIFT);
               prio_stack_q[depth_q] <= cur_prio_q;
               depth_q <= depth_q + 4'h1;
               cur_prio_q <= win_prio;
               ack_prio_out <= win_prio;
            end else begin
               // function call jumps to its target
               pend_target_q <= call_target_in;
            end
         end
         // upper then lower context, each its own area
         case (st_q)
            ST_SAVEU: begin
               // upper context to the list head
               ctx_store_out <= 1'b1;
               ctx_upper_out <= 1'b1;
               ctx_addr_out <= csa_free_q;
               // link word chains to previous area
               previous_context_info_q <= csa_free_q;
               csa_free_q <= csa_free_q + (`CECP_CSA_WORDS * 4);
               st_q <= ST_SAVEL;
            end
            ST_SAVEL: begin
               // lower context and fetch redirect in the same cycle
               // global registers not in either area
               ctx_store_out <= 1'b1;
               ctx_upper_out <= 1'b0;
               ctx_addr_out <= csa_free_q;
               csa_free_q <= csa_free_q + (`CECP_CSA_WORDS * 4);
               redirect_out <= 1'b1;
               redirect_pc_out <= pend_target_q;
               st_q <= ST_IDLE;
            end
            default: begin
               // return unwinds priority nesting
               if (ret_in && depth_q != 4'h0 && !start) begin
                  depth_q <= depth_q - 4'h1;
                  cur_prio_q <= prio_stack_q[depth_q - 4'h1];
               end
            end
         endcase
      end
   end
endmodule // cecp_core

// *** test/cecp_src_model.sv ***
// service request sources as the interrupt fabric would present them
module cecp_src_model #(
   parameter int NSRC = 4,
   parameter int PW = 8
) (
   input wire logic clk_in,
   input wire logic [NSRC-1:0] raise_in,
   input wire logic redirect_in,
   input wire logic [PW-1:0] ack_prio_in,
   output logic [NSRC-1:0] req_out,
   output logic [NSRC*PW-1:0] prio_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic redir_q = 1'b0;
   initial req_out = '0;
   always_comb for (int i = 0; i < NSRC; i++) prio_out[i*PW +: PW] = PW'(i + 1);
   // a request stays pending until the core has taken it
   always @(posedge clk_in) begin
      redir_q <= redirect_in;
      for (int i = 0; i < NSRC; i++) begin
         if (raise_in[i]) begin
            req_out[i] <= 1'b1;
         end else if (redir_q && ack_prio_in == PW'(i + 1)) begin
            req_out[i] <= 1'b0;
         end
      end
   end
endmodule // cecp_src_model

// *** test/cecp_core_asserts.sv ***
module cecp_core_chk (
   input wire sys_clk_in,
   input wire reset_n_in,
   input wire trap_req_in,
   input wire [7:0] trap_cause_number_in,
   input wire periph_acc_in,
   input wire sysreg_acc_in,
   input wire int_toggle_in,
   input wire redirect_out,
   input wire [31:0] redirect_pc_out,
   input wire d15_we_out,
   input wire [31:0] d15_data_out,
   input wire ctx_store_out,
   input wire ctx_upper_out,
   input wire [31:0] ctx_addr_out,
   input wire access_deny_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (!reset_n_in);
   csa_align_a: assert property (ctx_store_out |-> ctx_addr_out[5:0] == 6'h00)
      else $error("context area not aligned");
   area_pair_a: assert property (ctx_store_out && ctx_upper_out |=>
      ctx_store_out && !ctx_upper_out && ctx_addr_out != $past(ctx_addr_out))
      else $error("lower context not in its own area");
   switch_redir_a: assert property (ctx_store_out && !ctx_upper_out |-> redirect_out)
      else $error("context saved without redirect");
   redir_ctx_a: assert property (redirect_out |-> ctx_store_out && !ctx_upper_out
      && $past(ctx_store_out && ctx_upper_out)) else $error("redirect without context save");
   vec_align_a: assert property (redirect_out |-> redirect_pc_out[4:0] == 5'h00)
      else $error("entry not on block boundary");
   trap_cause_a: assert property (d15_we_out |-> d15_data_out[7:0] == $past(trap_cause_number_in))
      else $error("wrong cause number");
   trap_src_a: assert property (d15_we_out |-> $past(trap_req_in) || $past(trap_req_in, 2))
      else $error("cause written without trap");
   deny_cause_a: assert property (access_deny_out |->
      $past(periph_acc_in || sysreg_acc_in || int_toggle_in)) else $error("deny without access");
   cover property (redirect_out && ctx_store_out);
   cover property (d15_we_out);
   cover property (access_deny_out);
endmodule // cecp_core_chk
bind cecp_core cecp_core_chk chk_u (.sys_clk_in, .reset_n_in, .trap_req_in,
   .trap_cause_number_in, .periph_acc_in, .sysreg_acc_in, .int_toggle_in, .redirect_out,
   .redirect_pc_out, .d15_we_out, .d15_data_out, .ctx_store_out, .ctx_upper_out,
   .ctx_addr_out, .access_deny_out);

// *** test/tb.sv ***
`include "cecp_map.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int NSRC = 4;
   localparam int PW = 8;
   logic sys_clk_in = 1'b0;
   logic reset_n_in = 1'b0;
   logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
   logic s_axi_awvalid_in = 0, s_axi_wvalid_in = 0, s_axi_bready_in = 0;
   logic s_axi_arvalid_in = 0, s_axi_rready_in = 0, ret_in = 0;
   logic [31:0] s_axi_wdata_in = 32'h0, pc_in = 32'h100, call_target_in = 32'h0;
   logic [3:0] s_axi_wstrb_in = 4'hF;
   logic trap_req_in = 0, call_req_in = 0, periph_acc_in = 0, periph_prot_in = 0;
   logic sysreg_acc_in = 0, int_toggle_in = 0;
   logic [2:0] trap_class_in = 3'h0;
   logic [7:0] trap_cause_number_in = 8'h00;
   logic [NSRC-1:0] raise = '0;
   wire [NSRC-1:0] srv_req_in;
   wire [NSRC*PW-1:0] request_priority_number_in;
   wire s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
   wire s_axi_rvalid_out, redirect_out, d15_we_out, ctx_store_out, ctx_upper_out;
   wire access_deny_out, irq_out;
   wire [1:0] s_axi_bresp_out, s_axi_rresp_out;
   wire [31:0] s_axi_rdata_out, redirect_pc_out, d15_data_out, ctx_addr_out;
   wire [PW-1:0] ack_prio_out;
   int num_errors = 0, comparisons = 0, cyc = 0, n_redir = 0, n_deny = 0;
   logic [31:0] last_pc = 32'h0, last_d15 = 32'h0;
   cecp_core #(.NSRC(NSRC), .PW(PW)) dut_u (.sys_clk_in, .reset_n_in, .s_axi_awaddr_in,
      .s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
      .s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
      .s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
      .s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in, .srv_req_in,
      .request_priority_number_in, .trap_req_in, .trap_class_in, .trap_cause_number_in,
      .call_req_in, .call_target_in, .pc_in, .periph_acc_in, .periph_prot_in, .sysreg_acc_in,
      .int_toggle_in, .ret_in, .redirect_out, .redirect_pc_out, .d15_we_out, .d15_data_out,
      .ctx_store_out, .ctx_upper_out, .ctx_addr_out, .access_deny_out, .irq_out, .ack_prio_out);
   cecp_src_model #(.NSRC(NSRC), .PW(PW)) src_u (.clk_in(sys_clk_in), .raise_in(raise),
      .redirect_in(redirect_out), .ack_prio_in(ack_prio_out), .req_out(srv_req_in),
      .prio_out(request_priority_number_in));
   initial forever #4 sys_clk_in = ~sys_clk_in;
   // record redirects, cause writes and denials; hang guard
   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (redirect_out === 1'b1) begin
         n_redir <= n_redir + 1;
         last_pc <= redirect_pc_out;
      end
      if (d15_we_out === 1'b1) last_d15 <= d15_data_out;
      if (access_deny_out === 1'b1) n_deny <= n_deny + 1;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         num_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic close_out;
      $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
      if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // axi4-lite write, both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
         if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      end while (s_axi_bvalid_out !== 1'b1);
      r = s_axi_bresp_out;
      s_axi_bready_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      end while (s_axi_rvalid_out !== 1'b1);
      d = s_axi_rdata_out;
      r = s_axi_rresp_out;
      s_axi_rready_in <= 1'b0;
      @(posedge sys_clk_in);
   endtask
   // count redirects over a settling window
   task automatic settle(input string nm, input int exp_n);
      int n0;
      n0 = n_redir;
      repeat (10) @(posedge sys_clk_in);
      chk(nm, 32'(n_redir - n0), 32'(exp_n));
   endtask
   task automatic take(input int s, input string nm, input int exp_n);
      raise[s] <= 1'b1;
      @(posedge sys_clk_in);
      raise <= '0;
      settle(nm, exp_n);
   endtask
   task automatic pulse_ret;
      ret_in <= 1'b1;
      @(posedge sys_clk_in);
      ret_in <= 1'b0;
   endtask
   // one-cycle access attempt, bits {toggle, sysreg, periph}
   task automatic probe(input logic [2:0] k, input string nm, input int exp_n);
      int n0;
      n0 = n_deny;
      {int_toggle_in, sysreg_acc_in, periph_acc_in} <= k;
      @(posedge sys_clk_in);
      {int_toggle_in, sysreg_acc_in, periph_acc_in} <= 3'h0;
      repeat (4) @(posedge sys_clk_in);
      chk(nm, 32'(n_deny - n0), 32'(exp_n));
   endtask
   initial begin
      logic [31:0] v, pc1;
      logic [1:0] r;
      repeat (16) @(posedge sys_clk_in);
      reset_n_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      rd(`CECP_OFF_PSW, v, r);
      chk("psw reset", v, `CECP_RST_PSW);
      rd(`CECP_OFF_CSA_FREE, v, r);
      chk("area reset", v, `CECP_RST_CSA);
      rd(8'h3C, v, r);
      chk("unmapped rresp", {30'h0, r}, 32'h3);
      wr(8'h3C, 32'hFFFFFFFF, r);
      chk("unmapped bresp", {30'h0, r}, 32'h2);
      wr(`CECP_OFF_VEC_BASE, 32'h00001000, r);
      wr(`CECP_OFF_TRAP_BASE, 32'h00002000, r);
      wr(`CECP_OFF_IRQ_MASK, 32'h00000001, r);
      wr(`CECP_OFF_CTRL, 32'h00000001, r);
      $display("register test done");
      take(1, "src1 taken", 1);
      chk("src1 prio", 32'(ack_prio_out), 32'h2);
      pc1 = last_pc;
      chk("src1 vector", pc1, 32'h00001000 + (32'h2 << `CECP_VEC_SHIFT));
      take(0, "lower waits", 0);
      take(3, "higher preempts", 1);
      chk("src3 prio", 32'(ack_prio_out), 32'h4);
      chk("vector step", last_pc - pc1, 32'h40);
      take(3, "equal waits", 0);
      pulse_ret();
      settle("retaken after return", 1);
      pulse_ret();
      settle("still below", 0);
      pulse_ret();
      settle("lowest taken", 1);
      chk("src0 vector", last_pc, 32'h00001000 + (32'h1 << `CECP_VEC_SHIFT));
      pulse_ret();
      $display("service request test done");
      for (int c = 0; c < 8; c++) begin
         trap_class_in <= 3'(c);
         trap_cause_number_in <= 8'h50 + 8'(c);
         @(posedge sys_clk_in);
         trap_req_in <= 1'b1;
         @(posedge sys_clk_in);
         trap_req_in <= 1'b0;
         settle("trap taken", 1);
         chk("trap cause", last_d15 & 32'hFF, 32'h50 + 32'(c));
         chk("trap vector", last_pc, 32'h00002000 + (32'(c) << `CECP_VEC_SHIFT));
      end
      call_target_in <= 32'h00004040;
      call_req_in <= 1'b1;
      @(posedge sys_clk_in);
      call_req_in <= 1'b0;
      settle("call taken", 1);
      chk("call target", last_pc, 32'h00004040);
      $display("trap and call test done");
      wr(`CECP_OFF_PSW, 32'h00000000, r);
      probe(3'h1, "user0 periph", 1);
      probe(3'h4, "user0 toggle", 1);
      wr(`CECP_OFF_PSW, 32'h00000400, r);
      probe(3'h1, "user1 periph", 0);
      probe(3'h2, "user1 sysreg", 1);
      probe(3'h4, "user1 toggle", 0);
      periph_prot_in <= 1'b1;
      probe(3'h1, "user1 protected", 1);
      periph_prot_in <= 1'b0;
      wr(`CECP_OFF_PSW, `CECP_RST_PSW, r);
      probe(3'h2, "super sysreg", 0);
      probe(3'h4, "super toggle", 0);
      wr(`CECP_OFF_CSA_FREE, 32'h00010004, r);
      take(2, "misaligned refused", 0);
      rd(`CECP_OFF_IRQ_STAT, v, r);
      chk("area fault flag", v & 32'h10, 32'h10);
      wr(`CECP_OFF_CSA_FREE, `CECP_RST_CSA, r);
      settle("aligned taken", 1);
      rd(`CECP_OFF_CSA_FREE, v, r);
      chk("area step", v, `CECP_RST_CSA + 2 * `CECP_CSA_WORDS * 4);
      pulse_ret();
      chk("irq raised", 32'(irq_out), 32'h1);
      wr(`CECP_OFF_IRQ_MASK, 32'h0, r);
      chk("irq masked", 32'(irq_out), 32'h0);
      wr(`CECP_OFF_IRQ_STAT, 32'h1F, r);
      wr(`CECP_OFF_IRQ_MASK, 32'h1F, r);
      rd(`CECP_OFF_IRQ_STAT, v, r);
      chk("status cleared", v & 32'h1F, 32'h0);
      chk("irq cleared", 32'(irq_out), 32'h0);
      $display("privilege and interrupt test done");
      close_out();
   end
endmodule // tb
